// *** core/vrcm_master.sv ***
// Command master for the serial voltage link to an external regulator controller.
// Assumes the link clock comes from outside and is sampled on clk; the data pin is open drain.
`default_nettype none
`include "vrcm_defs.svh"
module vrcm_master #(
    parameter logic [7:0] MAX_CODE  = 8'hb5,
    parameter int         NUM_RAILS = 16
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Request side.
    input  wire logic                  reqValid,
    input  wire vrcm_pkg::vrcm_req_t   req,
    output logic                       reqReady,
    output logic                       reqRefused,
    input  wire logic                  lowCurrent,
    // Result side.
    output logic                       doneValid,
    output vrcm_pkg::vrcm_result_t     done,
    output logic                       initDone,
    output logic                       linkFault,
    // Link pins.
    input  wire logic                  linkClk,
    input  wire logic                  linkDataIn,
    output logic                       linkDataOut,
    output logic                       linkDataOe
);
    // Legal voltage codes: off, or above the unused band and not past the ceiling.
    function automatic logic codeLegal(input logic [7:0] code);
        codeLegal = (code == `VRCM_CODE_OFF) ||
                    (code > `VRCM_CODE_GAP_HI && code <= MAX_CODE);
    endfunction

    // Synchronisers; the third clock stage is only the edge detector's memory.
    logic       clkS1_q, clkS2_q, clkS3_q, datS1_q, datS2_q;
    logic       rise, fall;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clkS1_q <= 1'b0;
            clkS2_q <= 1'b0;
            clkS3_q <= 1'b0;
            datS1_q <= 1'b1;
            datS2_q <= 1'b1;
        end else begin
            clkS1_q <= linkClk;
            clkS2_q <= clkS1_q;
            clkS3_q <= clkS2_q;
            datS1_q <= linkDataIn;
            datS2_q <= datS1_q;
        end
    end
    assign rise = clkS2_q & ~clkS3_q;
    assign fall = ~clkS2_q & clkS3_q;

    // Sequencer state.
    vrcm_pkg::vrcm_state_t state_q, state_d;
    logic [24:0] shift_q, shift_d;
    logic [4:0]  bitCnt_q, bitCnt_d;
    logic        txRel_q, txRel_d;
    logic [1:0]  ack_q, ack_d;
    logic        ackCnt_q, ackCnt_d;
    logic [3:0]  cmd_q, cmd_d, rail_q, rail_d;
    logic [7:0]  code_q, code_d, savedPs_q, savedPs_d;
    logic        raiseLow_q, raiseLow_d, pendPs_q, pendPs_d;
    logic        initDone_q, initDone_d, fault_q, fault_d;
    logic        doneValid_q, doneValid_d, refused_q, refused_d;
    vrcm_pkg::vrcm_result_t done_q, done_d;
    logic [7:0]  lastCode_q [NUM_RAILS];
    logic [7:0]  lastCode_d [NUM_RAILS];
    logic [7:0]  ps_q       [NUM_RAILS];
    logic [7:0]  ps_d       [NUM_RAILS];
    logic        badReq;
    logic [3:0]  reqCmd;

    // Choice of command and refusal of requests that must never reach the link.
    always_comb begin
        reqCmd = `VRCM_CMD_GRADUAL;
        unique case (req.kind)
            vrcm_pkg::KIND_IDLE_EXIT:  reqCmd = `VRCM_CMD_QUICK;
            vrcm_pkg::KIND_IDLE_ENTER: reqCmd = (req.code < lastCode_q[req.rail]) ?
                                                `VRCM_CMD_PASSIVE : `VRCM_CMD_GRADUAL;
            vrcm_pkg::KIND_PSTATE:     reqCmd = `VRCM_CMD_PSTATE;
            vrcm_pkg::KIND_PERF:       reqCmd = `VRCM_CMD_GRADUAL;
        endcase
        // Odd rails are reserved offsets, so nothing is ever sent to them.
        badReq = req.rail[0] || 32'(req.rail) >= NUM_RAILS;
        if (req.kind == vrcm_pkg::KIND_PSTATE)
            badReq = badReq || req.code > `VRCM_PS_VLIGHT;
        else
            badReq = badReq || !codeLegal(req.code);
    end

    // Next-state logic of the frame sequencer.
    always_comb begin
        state_d     = state_q;
        shift_d     = shift_q;
        bitCnt_d    = bitCnt_q;
        txRel_d     = txRel_q;
        ack_d       = ack_q;
        ackCnt_d    = ackCnt_q;
        cmd_d       = cmd_q;
        rail_d      = rail_q;
        code_d      = code_q;
        savedPs_d   = savedPs_q;
        raiseLow_d  = raiseLow_q;
        pendPs_d    = pendPs_q;
        initDone_d  = initDone_q;
        fault_d     = fault_q;
        done_d      = done_q;
        doneValid_d = 1'b0;
        refused_d   = 1'b0;
        lastCode_d  = lastCode_q;
        ps_d        = ps_q;
        unique case (state_q)
            vrcm_pkg::ST_INIT: begin
                // Ceiling write goes out before any voltage command.
                cmd_d    = `VRCM_CMD_REGWR;
                rail_d   = `VRCM_RAIL_CORE;
                code_d   = MAX_CODE;
                shift_d  = {1'b0, `VRCM_RAIL_CORE, `VRCM_CMD_REGWR, `VRCM_REG_VOUT_MAX, MAX_CODE};
                bitCnt_d = `VRCM_LEN_LONG;
                state_d  = vrcm_pkg::ST_SEND;
            end
            vrcm_pkg::ST_IDLE: begin
                if (pendPs_q) begin
                    // Low current persists at the raised voltage: restore the light-load state.
                    pendPs_d = 1'b0;
                    cmd_d    = `VRCM_CMD_PSTATE;
                    code_d   = savedPs_q;
                    shift_d  = {1'b0, rail_q, `VRCM_CMD_PSTATE, savedPs_q, 8'h00};
                    bitCnt_d = `VRCM_LEN_SHORT;
                    raiseLow_d = 1'b0;
                    state_d  = vrcm_pkg::ST_SEND;
                end else if (reqValid && initDone_q) begin
                    if (badReq) begin
                        refused_d = 1'b1;
                    end else begin
                        cmd_d    = reqCmd;
                        rail_d   = req.rail;
                        code_d   = req.code;
                        // Payload byte holds the voltage code or the power-state code.
                        shift_d  = {1'b0, req.rail, reqCmd, req.code, 8'h00};
                        bitCnt_d = `VRCM_LEN_SHORT;
                        // The regulator leaves low power on a raise, so remember its old state.
                        raiseLow_d = reqCmd != `VRCM_CMD_PSTATE && req.code > lastCode_q[req.rail] &&
                                     ps_q[req.rail] != `VRCM_PS_FULL;
                        savedPs_d  = ps_q[req.rail];
                        state_d  = vrcm_pkg::ST_SEND;
                    end
                end
            end
            vrcm_pkg::ST_SEND: begin
                // Bits change on the falling link edge so they are stable at the rising one.
                if (fall) begin
                    if (bitCnt_q == 5'h00) begin
                        txRel_d = 1'b1;
                        state_d = vrcm_pkg::ST_TURN;
                    end else begin
                        txRel_d  = shift_q[24];
                        shift_d  = {shift_q[23:0], 1'b1};
                        bitCnt_d = bitCnt_q - 5'h01;
                    end
                end
            end
            vrcm_pkg::ST_TURN: begin
                if (fall) begin
                    ackCnt_d = 1'b0;
                    state_d  = vrcm_pkg::ST_ACK;
                end
            end
            vrcm_pkg::ST_ACK: begin
                if (rise) begin
                    ack_d    = {ack_q[0], datS2_q};
                    ackCnt_d = 1'b1;
                    if (ackCnt_q) begin
                        // Acknowledge closes the frame before another may start.
                        state_d     = vrcm_pkg::ST_IDLE;
                        doneValid_d = 1'b1;
                        done_d      = '{cmd: cmd_q, rail: rail_q, ack: {ack_q[0], datS2_q}};
                        if ({ack_q[0], datS2_q} == `VRCM_ACK_NOTSUP)
                            fault_d = 1'b1;
                        if (cmd_q == `VRCM_CMD_REGWR)
                            initDone_d = {ack_q[0], datS2_q} == `VRCM_ACK_OK;
                        if ({ack_q[0], datS2_q} == `VRCM_ACK_OK) begin
                            if (cmd_q == `VRCM_CMD_PSTATE) begin
                                ps_d[rail_q] = code_q;
                            end else if (cmd_q != `VRCM_CMD_REGWR) begin
                                lastCode_d[rail_q] = code_q;
                                if (raiseLow_q) begin
                                    ps_d[rail_q] = `VRCM_PS_FULL;
                                    pendPs_d     = lowCurrent;
                                end
                            end
                        end
                        // A rejected power state leaves the recorded state unchanged.
                    end
                end
            end
            default: state_d = vrcm_pkg::ST_INIT;
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q     <= vrcm_pkg::ST_INIT;
            shift_q     <= 25'h1ffffff;
            bitCnt_q    <= 5'h00;
            txRel_q     <= 1'b1;
            ack_q       <= `VRCM_ACK_NONE;
            ackCnt_q    <= 1'b0;
            cmd_q       <= 4'h0;
            rail_q      <= `VRCM_RAIL_CORE;
            code_q      <= `VRCM_CODE_OFF;
            savedPs_q   <= `VRCM_PS_FULL;
            raiseLow_q  <= 1'b0;
            pendPs_q    <= 1'b0;
            initDone_q  <= 1'b0;
            fault_q     <= 1'b0;
            doneValid_q <= 1'b0;
            refused_q   <= 1'b0;
            done_q      <= '0;
            for (int i = 0; i < NUM_RAILS; i++) begin
                lastCode_q[i] <= `VRCM_CODE_OFF;
                ps_q[i]       <= `VRCM_PS_FULL;
            end
        end else begin
            state_q     <= state_d;
            shift_q     <= shift_d;
            bitCnt_q    <= bitCnt_d;
            txRel_q     <= txRel_d;
            ack_q       <= ack_d;
            ackCnt_q    <= ackCnt_d;
            cmd_q       <= cmd_d;
            rail_q      <= rail_d;
            code_q      <= code_d;
            savedPs_q   <= savedPs_d;
            raiseLow_q  <= raiseLow_d;
            pendPs_q    <= pendPs_d;
            initDone_q  <= initDone_d;
            fault_q     <= fault_d;
            doneValid_q <= doneValid_d;
            refused_q   <= refused_d;
            done_q      <= done_d;
            lastCode_q  <= lastCode_d;
            ps_q        <= ps_d;
        end
    end

    // Outputs; the pin only ever pulls low, a one is the released line.
    assign reqReady    = state_q == vrcm_pkg::ST_IDLE && initDone_q && !pendPs_q;
    assign reqRefused  = refused_q;
    assign doneValid   = doneValid_q;
    assign done        = done_q;
    assign initDone    = initDone_q;
    assign linkFault   = fault_q;
    assign linkDataOut = 1'b0;
    assign linkDataOe  = ~txRel_q;

    // Checks.
    sequence s_raiseLowOk;
        doneValid && done.ack == `VRCM_ACK_OK && $past(raiseLow_q) && $past(lowCurrent);
    endsequence
    sequence s_psIssued;
        state_q == vrcm_pkg::ST_SEND && cmd_q == `VRCM_CMD_PSTATE;
    endsequence
    a_init_first: assert property (@(posedge clk) disable iff (reset)
        state_q == vrcm_pkg::ST_SEND && !initDone_q |-> cmd_q == `VRCM_CMD_REGWR && code_q == MAX_CODE)
        else $error("Voltage command sent before ceiling write.");
    a_gap_codes: assert property (@(posedge clk) disable iff (reset)
        state_q == vrcm_pkg::ST_SEND && cmd_q != `VRCM_CMD_PSTATE |->
        !(code_q >= `VRCM_CODE_GAP_LO && code_q <= `VRCM_CODE_GAP_HI))
        else $error("Unused voltage code commanded.");
    a_odd_rail: assert property (@(posedge clk) disable iff (reset)
        state_q == vrcm_pkg::ST_SEND |-> !rail_q[0])
        else $error("Frame addressed to an odd rail.");
    a_idle_exit: assert property (@(posedge clk) disable iff (reset)
        state_q == vrcm_pkg::ST_IDLE && reqReady && reqValid && !badReq &&
        req.kind == vrcm_pkg::KIND_IDLE_EXIT |=> cmd_q == `VRCM_CMD_QUICK && state_q == vrcm_pkg::ST_SEND)
        else $error("Idle exit did not use a quick set.");
    a_idle_enter: assert property (@(posedge clk) disable iff (reset)
        reqReady && reqValid && !badReq && req.kind == vrcm_pkg::KIND_IDLE_ENTER &&
        req.code < lastCode_q[req.rail] |=> cmd_q == `VRCM_CMD_PASSIVE)
        else $error("Idle entry fall did not use the passive set.");
    a_perf_set: assert property (@(posedge clk) disable iff (reset)
        reqReady && reqValid && !badReq && req.kind == vrcm_pkg::KIND_PERF |=> cmd_q == `VRCM_CMD_GRADUAL)
        else $error("Performance change did not use the gradual set.");
    a_ps_code: assert property (@(posedge clk) disable iff (reset)
        s_psIssued |-> code_q <= `VRCM_PS_VLIGHT)
        else $error("Power-state code out of range.");
    a_ps_reissue: assert property (@(posedge clk) disable iff (reset)
        s_raiseLowOk |-> ##[1:2] s_psIssued)
        else $error("Low power state not reissued after raise.");
    a_payload: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == vrcm_pkg::ST_SEND) && cmd_q != `VRCM_CMD_REGWR |->
        shift_q[24:0] == {1'b0, rail_q, cmd_q, code_q, 8'h00})
        else $error("Frame not laid out as rail, command, payload.");
    a_ack_gap: assert property (@(posedge clk) disable iff (reset)
        $fell(state_q == vrcm_pkg::ST_ACK) |-> doneValid && state_q == vrcm_pkg::ST_IDLE)
        else $error("Frame left the answer phase without finishing.");
    a_not_sup: assert property (@(posedge clk) disable iff (reset)
        doneValid && done.ack == `VRCM_ACK_NOTSUP |-> linkFault)
        else $error("Not supported answer did not raise the fault.");
endmodule
`default_nettype wire

// *** shared/vrcm_defs.svh ***
// Constants of the voltage regulator command master: link codes and frame sizes.
// Assumes it is included by the core, the regulator model and the bench by its bare name.
`ifndef VRCM_DEFS_SVH
`define VRCM_DEFS_SVH
// Command codes carried in the command field of a frame.
`define VRCM_CMD_QUICK      4'h1
`define VRCM_CMD_GRADUAL    4'h2
`define VRCM_CMD_PASSIVE    4'h3
`define VRCM_CMD_PSTATE     4'h4
`define VRCM_CMD_REGWR      4'h5
// Regulator power-state codes.
`define VRCM_PS_FULL        8'h00
`define VRCM_PS_LIGHT       8'h01
`define VRCM_PS_VLIGHT      8'h02
// Regulator register that holds the highest allowed voltage code.
`define VRCM_REG_VOUT_MAX   8'h30
// Voltage codes: off, and the band that is never commanded.
`define VRCM_CODE_OFF       8'h00
`define VRCM_CODE_GAP_LO    8'h01
`define VRCM_CODE_GAP_HI    8'h65
// Core supply rail address.
`define VRCM_RAIL_CORE      4'h0
// Acknowledge codes returned by the regulator.
`define VRCM_ACK_NONE       2'h0
`define VRCM_ACK_OK         2'h1
`define VRCM_ACK_NOTSUP     2'h2
`define VRCM_ACK_REJECT     2'h3
// Frame lengths in bits, start bit included.
`define VRCM_LEN_SHORT      5'h11
`define VRCM_LEN_LONG       5'h19
`endif

// *** shared/vrcm_pkg.sv ***
// Types shared by the voltage regulator command master and its bench.
// Assumes vrcm_defs.svh is on the include path.
`default_nettype none
package vrcm_pkg;
    // What the power manager asks for.
    typedef enum logic [1:0] {
        KIND_PERF       = 2'b00,
        KIND_IDLE_ENTER = 2'b01,
        KIND_IDLE_EXIT  = 2'b10,
        KIND_PSTATE     = 2'b11
    } vrcm_kind_t;
    // Request from the power manager.
    typedef struct packed {
        vrcm_kind_t kind;
        logic [3:0] rail;
        logic [7:0] code;
    } vrcm_req_t;
    // Outcome of one finished frame.
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] rail;
        logic [1:0] ack;
    } vrcm_result_t;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_TURN = 3'b011,
        ST_ACK  = 3'b100
    } vrcm_state_t;
endpackage
`default_nettype wire

// *** dv/vrcm_reg_model.sv ***
// Behavioural regulator controller on the far side of the serial voltage link.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
`include "vrcm_defs.svh"
module vrcm_reg_model (
    // Link pins.
    input  wire logic        linkClk,
    input  wire logic        lineLevel,
    output logic             pullLow,
    // Bench controls.
    input  wire logic [7:0]  limitCode,
    input  wire logic [2:0]  psSupported,
    input  wire logic        socketEmptyFlagN,
    // Observed state.
    output var int           frameCount,
    output logic [7:0]       lastReg,
    output logic [15:0]      lastFrame,
    output logic             outputOn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] shiftReg;
    logic [1:0]  ack;
    logic [1:0]  slewMode;
    logic [7:0]  targetCode;
    logic [7:0]  psState;
    logic        notSupSeen;
    // Start released, full power, nothing received yet.
    initial begin
        pullLow = 1'b0;
        frameCount = 0;
        psState = `VRCM_PS_FULL;
        targetCode = `VRCM_CODE_OFF;
        notSupSeen = 1'b0;
    end
    // The output stays off while socketEmptyFlagN is high or once a ceiling was refused.
    assign outputOn = !socketEmptyFlagN && !notSupSeen;
    // Frame: start bit, rail, command, payload; then a turnaround and a two-bit answer.
    always begin
        @(posedge linkClk);
        if (lineLevel === 1'b0) begin
            for (int i = 0; i < 16; i++) begin
                @(posedge linkClk);
                shiftReg = {shiftReg[22:0], lineLevel};
            end
            lastFrame = shiftReg[15:0];
            if (shiftReg[11:8] == `VRCM_CMD_REGWR) begin
                lastReg = shiftReg[7:0];
                for (int i = 0; i < 8; i++) begin
                    @(posedge linkClk);
                    shiftReg = {shiftReg[22:0], lineLevel};
                end
                lastFrame[7:0] = shiftReg[7:0];
            end
            ack = `VRCM_ACK_OK;
            if (lastFrame[11:8] == `VRCM_CMD_REGWR) begin
                if (lastReg == `VRCM_REG_VOUT_MAX && lastFrame[7:0] > limitCode) begin
                    ack = `VRCM_ACK_NOTSUP;
                    notSupSeen = 1'b1;
                end
            end else if (lastFrame[11:8] == `VRCM_CMD_PSTATE) begin
                if (lastFrame[7:0] > 8'h02 || !psSupported[lastFrame[1:0]]) ack = `VRCM_ACK_REJECT;
                else psState = lastFrame[7:0];
            end else begin
                // A raise leaves low power first; every set abandons the ramp in flight.
                if (lastFrame[7:0] > targetCode) psState = `VRCM_PS_FULL;
                targetCode = lastFrame[7:0];
                slewMode = lastFrame[9:8];
            end
            frameCount++;
            @(negedge linkClk);
            @(negedge linkClk);
            pullLow = !ack[1];
            @(negedge linkClk);
            pullLow = !ack[0];
            @(negedge linkClk);
            pullLow = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the voltage regulator command master.
// Assumes vrcm_defs.svh on the include path and the regulator model beside it.
`default_nettype none
`include "vrcm_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MaxCode = 8'hb5;
    logic clk, reset, reqValid, reqReady, reqRefused, lowCurrent, doneValid, initDone, linkFault;
    logic linkClk, dutOut, dutOe, modelPull, sockEmptyN, outputOn;
    logic [7:0] limitCode, lastReg, psRec, c;
    logic [15:0] lastFrame;
    logic [2:0] psSupported;
    logic [3:0] r;
    logic [7:0] lastCode [16];
    bit known [16];
    int failures, testsRun, cycles, frameCount, expFrames;
    wire logic lineLevel;
    vrcm_pkg::vrcm_req_t req;
    vrcm_pkg::vrcm_result_t done;
    vrcm_pkg::vrcm_kind_t k;
    logic [7:0] corner [7] = '{8'h00, 8'h01, 8'h65, 8'h66, 8'hb5, 8'hb6, 8'hff};
    // Open drain with pull-up: low while either party pulls.
    assign lineLevel = ((dutOe && !dutOut) || modelPull) ? 1'b0 : 1'b1;
    vrcm_master #(.MAX_CODE(MaxCode), .NUM_RAILS(16)) dut (.clk(clk), .reset(reset), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .reqRefused(reqRefused), .lowCurrent(lowCurrent),
        .doneValid(doneValid), .done(done), .initDone(initDone), .linkFault(linkFault),
        .linkClk(linkClk), .linkDataIn(lineLevel), .linkDataOut(dutOut), .linkDataOe(dutOe));
    vrcm_reg_model model (.linkClk(linkClk), .lineLevel(lineLevel), .pullLow(modelPull),
        .limitCode(limitCode), .psSupported(psSupported), .socketEmptyFlagN(sockEmptyN),
        .frameCount(frameCount), .lastReg(lastReg), .lastFrame(lastFrame), .outputOn(outputOn));
    // Clocks: the link clock is free running and out of phase with clk.
    always #4 clk = ~clk;
    initial begin
        linkClk = 1'b0;
        #13;
        forever #40 linkClk = ~linkClk;
    end
    // A hang is cut short and counted.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            close_out();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [3:0] exp_cmd(input vrcm_pkg::vrcm_kind_t kk, input logic [7:0] cc, input logic [7:0] l);
        case (kk)
            vrcm_pkg::KIND_IDLE_EXIT: return `VRCM_CMD_QUICK;
            vrcm_pkg::KIND_IDLE_ENTER: return (cc < l) ? `VRCM_CMD_PASSIVE : `VRCM_CMD_GRADUAL;
            vrcm_pkg::KIND_PSTATE: return `VRCM_CMD_PSTATE;
            default: return `VRCM_CMD_GRADUAL;
        endcase
    endfunction
    // Entered at a falling edge; leaves one cycle past the pulse.
    task automatic wait_done(output vrcm_pkg::vrcm_result_t res);
        for (int n = 0; n < 4000 && doneValid !== 1'b1; n++) @(negedge clk);
        check("doneValid", 16'h1, {15'h0, doneValid});
        res = done;
        @(negedge clk);
    endtask
    // Holds the request until taken, then looks for the refusal pulse.
    task automatic run(input vrcm_pkg::vrcm_kind_t kk, input logic [3:0] rr, input logic [7:0] cc, input logic [1:0] a);
        vrcm_pkg::vrcm_result_t res;
        logic [3:0] cmd;
        bit bad, raise;
        bad = rr[0] || (kk == vrcm_pkg::KIND_PSTATE ? cc > 8'h02 : ((cc != 8'h00 && cc <= 8'h65) || cc > MaxCode));
        cmd = exp_cmd(kk, cc, lastCode[rr]);
        raise = known[rr] && cc > lastCode[rr];
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{kind: kk, rail: rr, code: cc};
        do @(negedge clk); while (reqReady !== 1'b1);
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk);
        check("reqRefused", {15'h0, bad}, {15'h0, reqRefused});
        if (!bad) begin
            wait_done(res);
            expFrames++;
            check("done", {6'h0, cmd, rr, a}, {6'h0, res});
            check("frame", {rr, cmd, cc}, lastFrame);
            if (kk == vrcm_pkg::KIND_PSTATE) begin
                if (a == `VRCM_ACK_OK) psRec = cc;
            end else begin
                if (raise && psRec != `VRCM_PS_FULL) begin
                    if (lowCurrent) begin
                        wait_done(res);
                        expFrames++;
                        check("reissue", {rr, `VRCM_CMD_PSTATE, psRec}, lastFrame);
                    end else psRec = `VRCM_PS_FULL;
                end
                lastCode[rr] = cc;
                known[rr] = 1'b1;
            end
            check("frames", 16'(expFrames), 16'(frameCount));
        end
    endtask
    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Init, random traffic with corners, power states, then a refused ceiling.
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        reqValid = 1'b0;
        req = '0;
        lowCurrent = 1'b0;
        limitCode = MaxCode;
        psSupported = 3'b011;
        sockEmptyN = 1'b0;
        psRec = `VRCM_PS_FULL;
        void'($urandom(59));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int n = 0; n < 4000 && initDone !== 1'b1; n++) @(negedge clk);
        expFrames = 1;
        check("init", 16'h1, {15'h0, initDone});
        check("ceiling", {`VRCM_RAIL_CORE, `VRCM_CMD_REGWR, MaxCode}, lastFrame);
        check("ceilReg", {8'h0, `VRCM_REG_VOUT_MAX}, {8'h0, lastReg});
        check("outputOn", 16'h1, {15'h0, outputOn});
        for (int i = 0; i < 30; i++) begin
            k = vrcm_pkg::vrcm_kind_t'($urandom_range(0, 2));
            r = 4'($urandom_range(0, 7) * 2 + ($urandom_range(0, 7) == 0));
            c = (i < 7) ? corner[i] : 8'($urandom_range(8'h66, MaxCode));
            if (k == vrcm_pkg::KIND_IDLE_ENTER && !known[r]) k = vrcm_pkg::KIND_PERF;
            @(posedge clk) lowCurrent <= 1'($urandom_range(0, 1));
            run(k, r, c, `VRCM_ACK_OK);
        end
        @(posedge clk) lowCurrent <= 1'b0;
        run(vrcm_pkg::KIND_PERF, 4'h0, 8'h80, `VRCM_ACK_OK);
        for (int p = 0; p < 4; p++) begin
            run(vrcm_pkg::KIND_PSTATE, 4'h0, 8'(p), (p == 2) ? `VRCM_ACK_REJECT : `VRCM_ACK_OK);
        end
        @(posedge clk) lowCurrent <= 1'b1;
        run(vrcm_pkg::KIND_IDLE_EXIT, 4'h0, 8'h90, `VRCM_ACK_OK);
        @(posedge clk) lowCurrent <= 1'b0;
        run(vrcm_pkg::KIND_PERF, 4'h0, 8'ha0, `VRCM_ACK_OK);
        @(posedge clk) lowCurrent <= 1'b1;
        run(vrcm_pkg::KIND_PERF, 4'h0, 8'hb0, `VRCM_ACK_OK);
        limitCode <= 8'h90;
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int n = 0; n < 4000 && linkFault !== 1'b1; n++) @(negedge clk);
        check("fault", 16'h1, {14'h0, initDone, linkFault});
        check("ready", 16'h0, {14'h0, reqReady, outputOn});
        close_out();
    end
endmodule
`default_nettype wire
